// ---- bench/rtil_chk_asserts.sv ----
/*
  Port checker of the trip interlock block.
  Assumes binding to rtil_top and a fixed three-edge pin to output delay.
*/
`timescale 1ns/1ps
module rtil_chk #(
  parameter NUM_SV = 4
) (
  input wire              MCLK,
  input wire              SRST,
  input wire              PSEL,
  input wire              PENABLE,
  input wire              PREADY,
  input wire [11:0]       TRN_A_OK,
  input wire [11:0]       TRN_B_OK,
  input wire [1:0]        IR_BELOW,
  input wire [3:0]        PR_BELOW,
  input wire [1:0]        IMP_BELOW,
  input wire [NUM_SV-1:0] SV_OPEN,
  input wire [2:0]        TFP_OK,
  input wire              TRIP_N,
  input wire              GW_TRIP_N,
  input wire              ALARM_A,
  input wire              ALARM_B,
  input wire              P6,
  input wire              P7,
  input wire              P8,
  input wire              P9,
  input wire              P10,
  input wire              SR_BLOCKED,
  input wire              HV_ON,
  input wire [1:0]        IR_BLOCKED,
  input wire [1:0]        PRL_BLOCKED,
  input wire              TURB_TRIP
);
  // ****************************************************************
  // warm-up: synchronisers hold reset values for a few edges
  // ****************************************************************
  logic [2:0] up_q;
  always @(posedge MCLK)
  begin
    if (SRST)
      up_q <= 3'h0;
    else if (up_q != 3'h7)
      up_q <= up_q + 3'h1;
  end
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST || up_q != 3'h7);
  // ****************************************************************
  // properties
  // ****************************************************************
  property p_al_a; ALARM_A == $past(~&TRN_A_OK, 3); endproperty
  a_al_a: assert property (p_al_a) else $error("train A alarm wrong");
  property p_al_b; ALARM_B == $past(~&TRN_B_OK, 3); endproperty
  a_al_b: assert property (p_al_b) else $error("train B alarm wrong");
  property p_gw; GW_TRIP_N == !$past((~&TRN_A_OK) && (~&TRN_B_OK), 3); endproperty
  a_gw: assert property (p_gw) else $error("coincidence trip wrong");
  property p_trip; !GW_TRIP_N |-> !TRIP_N; endproperty
  a_trip: assert property (p_trip) else $error("warning trip not passed on");
  property p_p6; P6 == $past(~&IR_BELOW, 3); endproperty
  a_p6: assert property (p_p6) else $error("intermediate permissive wrong");
  property p_p7; P7 == !$past(($countones(PR_BELOW) > 2) && (&IMP_BELOW), 3); endproperty
  a_p7: assert property (p_p7) else $error("low power interlock wrong");
  property p_p89; P8 == P9 && P9 == $past($countones(PR_BELOW) < 3, 3); endproperty
  a_p89: assert property (p_p89) else $error("flux interlocks wrong");
  property p_p10; P10 == $past($countones(PR_BELOW) < 3, 3); endproperty
  a_p10: assert property (p_p10) else $error("power range permissive wrong");
  property p_sr_hi; P10 [*4] |-> SR_BLOCKED && !HV_ON; endproperty
  a_sr_hi: assert property (p_sr_hi) else $error("source range not held blocked");
  property p_sr_lo; !P6 [*4] |-> !SR_BLOCKED && HV_ON; endproperty
  a_sr_lo: assert property (p_sr_lo) else $error("source range not restored");
  property p_blk; !P10 [*3] |-> IR_BLOCKED == 2'h0 && PRL_BLOCKED == 2'h0; endproperty
  a_blk: assert property (p_blk) else $error("range block outside permissive");
  property p_turb;
    TURB_TRIP == $past((SV_OPEN == '0) || ($countones(TFP_OK) < 2), 3);
  endproperty
  a_turb: assert property (p_turb) else $error("turbine trip sensing wrong");
  property p_rdy; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("bus answer late");
endmodule

bind rtil_top rtil_chk #(.NUM_SV(NUM_SV)) rtil_chk_inst (
  .MCLK(MCLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .TRN_A_OK(TRN_A_OK), .TRN_B_OK(TRN_B_OK), .IR_BELOW(IR_BELOW), .PR_BELOW(PR_BELOW),
  .IMP_BELOW(IMP_BELOW), .SV_OPEN(SV_OPEN), .TFP_OK(TFP_OK), .TRIP_N(TRIP_N),
  .GW_TRIP_N(GW_TRIP_N), .ALARM_A(ALARM_A), .ALARM_B(ALARM_B), .P6(P6), .P7(P7),
  .P8(P8), .P9(P9), .P10(P10), .SR_BLOCKED(SR_BLOCKED), .HV_ON(HV_ON),
  .IR_BLOCKED(IR_BLOCKED), .PRL_BLOCKED(PRL_BLOCKED), .TURB_TRIP(TURB_TRIP));

// ---- bench/rtil_plant.sv ----
/*
  Plant bistable model: turns a power band and fault masks into channel levels.
  Assumes the bench changes its inputs at clock edges.
*/
`timescale 1ns/1ps
module rtil_plant #(
  parameter NUM_SV = 4
) (
  input  wire [1:0]        band,
  input  wire              imp_lo,
  input  wire [11:0]       fault_a,
  input  wire [11:0]       fault_b,
  input  wire [1:0]        tt,
  output wire [11:0]       trn_a_ok,
  output wire [11:0]       trn_b_ok,
  output wire [1:0]        ir_below,
  output wire [3:0]        pr_below,
  output wire [1:0]        imp_below,
  output wire [NUM_SV-1:0] sv_open,
  output wire [2:0]        tfp_ok
);
  // energised means normal, so a fault drops the level
  assign trn_a_ok  = ~fault_a;
  assign trn_b_ok  = ~fault_b;
  // band 1 sits exactly at one channel above and three below
  assign ir_below  = band == 2'h0 ? 2'h3 : (band == 2'h1 ? 2'h2 : 2'h0);
  assign pr_below  = band == 2'h0 ? 4'hF : (band == 2'h1 ? 4'h7 : (band == 2'h2 ? 4'h3 : 4'h0));
  assign imp_below = imp_lo ? 2'h3 : 2'h0;
  assign sv_open   = tt == 2'h1 ? '0 : '1;
  assign tfp_ok    = tt == 2'h2 ? 3'h4 : (tt == 2'h3 ? 3'h6 : 3'h7);
endmodule

// ---- bench/test_reactor_trip_interlock_logic.sv ----
/*
  Self-checking bench of the trip interlock block.
  Assumes rtil_top, the plant model rtil_plant and the bound checker.
*/
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    n_checks++; \
    if ((a) !== (e)) \
    begin \
      n_mismatch++; \
      $display("unexpected at %0t: got %h exp %h", $time, a, e); \
    end \
  end
module test_reactor_trip_interlock_logic;
  logic        mclk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e, imp_lo = 1'b1, uv = 1'b1, uf = 1'b1, lp = 1'b1, hl = 1'b1;
  logic [1:0]  band = 2'h0, tt = 2'h0, sr_rst = 2'h0, ir_sw = 2'h0, prl_sw = 2'h0;
  logic [11:0] fault_a = 12'h0, fault_b = 12'h0, trn_a, trn_b;
  logic [3:0]  flow_ok = 4'hF, pr_below, sv_open;
  logic [1:0]  ir_below, imp_below, ir_blk, prl_blk;
  logic [2:0]  tfp_ok, hi_ok = 3'h7;
  logic        trip_n, gw_n, al_a, al_b, p6, p7, p8, p9, p10, sr_blk, hv, turb;
  int          n_mismatch = 0, n_checks = 0;
  always #5 mclk = ~mclk;
  rtil_plant rtil_plant_inst (.band(band), .imp_lo(imp_lo), .fault_a(fault_a),
    .fault_b(fault_b), .tt(tt), .trn_a_ok(trn_a), .trn_b_ok(trn_b), .ir_below(ir_below),
    .pr_below(pr_below), .imp_below(imp_below), .sv_open(sv_open), .tfp_ok(tfp_ok));
  rtil_top rtil_top_inst (.MCLK(mclk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .TRN_A_OK(trn_a), .TRN_B_OK(trn_b), .IR_BELOW(ir_below),
    .PR_BELOW(pr_below), .IMP_BELOW(imp_below), .SV_OPEN(sv_open), .TFP_OK(tfp_ok),
    .SR_RESET_A(sr_rst[0]), .SR_RESET_B(sr_rst[1]), .IR_BLK_SW(ir_sw),
    .PRL_BLK_SW(prl_sw), .LOOP_FLOW_OK(flow_ok), .RCP_UV_OK(uv), .RCP_UF_OK(uf),
    .PZR_LP_OK(lp), .PZR_HL_OK(hl), .SR_HI_OK(hi_ok[0]), .IR_HI_OK(hi_ok[1]),
    .PRL_HI_OK(hi_ok[2]),
    .TRIP_N(trip_n), .GW_TRIP_N(gw_n), .ALARM_A(al_a), .ALARM_B(al_b), .P6(p6), .P7(p7),
    .P8(p8), .P9(p9), .P10(p10), .SR_BLOCKED(sr_blk), .HV_ON(hv), .IR_BLOCKED(ir_blk),
    .PRL_BLOCKED(prl_blk), .TURB_TRIP(turb));
  // ****************************************************************
  // bus and timing tasks
  // ****************************************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ends on an edge so the caller's next drive lands on that edge
  task automatic settle();
    repeat (6) @(posedge mclk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #300us;
    n_mismatch++;
    close_out();
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    settle();
    apb(1'b0, 8'h04, 32'h0); `CHK(r, 32'h00000403)
    apb(1'b0, 8'h0C, 32'h0); `CHK({e, r}, {1'b1, 32'h0})
    done("registers");
    for (int i = 0; i < 12; i++)
    begin
      fault_a <= 12'h001 << i;
      settle(); `CHK({al_a, al_b, gw_n, trip_n}, 4'hB)
      fault_b <= 12'h800 >> i;
      settle(); `CHK({al_a, al_b, gw_n, trip_n}, 4'hC)
      apb(1'b0, 8'h08, 32'h0); `CHK(r, {4'h0, ~(12'h800 >> i), 4'h0, ~(12'h001 << i)})
      fault_a <= 12'h000;
      settle(); `CHK({al_a, al_b, gw_n, trip_n}, 4'h7)
      fault_b <= 12'h000;
    end
    done("trouble");
    apb(1'b1, 8'h00, 32'h1);
    settle(); `CHK(sr_blk, 1'b0)
    band <= 2'h1;
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, 8'h00, 32'h1);
      settle(); `CHK({sr_blk, hv}, 2'h2)
      sr_rst[k] <= 1'b1;
      settle(); `CHK({sr_blk, hv}, 2'h1)
      sr_rst[k] <= 1'b0;
    end
    apb(1'b1, 8'h00, 32'h1);
    settle(); `CHK({sr_blk, hv}, 2'h2)
    apb(1'b1, 8'h00, 32'h2);
    settle(); `CHK({sr_blk, hv}, 2'h1)
    apb(1'b1, 8'h00, 32'h1);
    band <= 2'h0;
    settle(); `CHK({sr_blk, hv}, 2'h1)
    band <= 2'h2;
    sr_rst <= 2'h3;
    settle(); `CHK({sr_blk, hv}, 2'h2)
    sr_rst <= 2'h0;
    band <= 2'h1;
    ir_sw <= 2'h1;
    settle(); `CHK(ir_blk, 2'h0)
    ir_sw <= 2'h0;
    band <= 2'h2;
    settle();
    ir_sw <= 2'h1;
    prl_sw <= 2'h2;
    settle(); `CHK({ir_blk, prl_blk}, 4'h6)
    hi_ok <= 3'h6;
    settle(); `CHK(trip_n, 1'b1)
    hi_ok <= 3'h5;
    settle(); `CHK(trip_n, 1'b0)
    hi_ok <= 3'h7;
    band <= 2'h1;
    settle(); `CHK({ir_blk, prl_blk}, 4'h0)
    ir_sw <= 2'h0;
    prl_sw <= 2'h0;
    done("permissives");
    for (int k = 0; k < 5; k++)
    begin
      band <= 2'h1;
      flow_ok <= k == 0 ? 4'hC : 4'hF;
      uv <= k != 1;
      uf <= k != 2;
      lp <= k != 3;
      hl <= k != 4;
      settle(); `CHK(trip_n, 1'b1)
      band <= 2'h3;
      settle(); `CHK(trip_n, 1'b0)
      {flow_ok, uv, uf, lp, hl} <= 8'hFF;
      settle();
    end
    band <= 2'h1;
    imp_lo <= 1'b0;
    flow_ok <= 4'hE;
    settle(); `CHK(trip_n, 1'b1)
    flow_ok <= 4'hC;
    settle(); `CHK(trip_n, 1'b0)
    band <= 2'h2;
    flow_ok <= 4'hE;
    settle(); `CHK(trip_n, 1'b0)
    flow_ok <= 4'hF;
    imp_lo <= 1'b1;
    done("low power");
    for (int t = 1; t < 4; t++)
    begin
      band <= 2'h1;
      tt <= t[1:0];
      settle(); `CHK({turb, trip_n}, t == 3 ? 2'h1 : 2'h3)
      band <= 2'h3;
      settle(); `CHK({turb, trip_n}, t == 3 ? 2'h1 : 2'h2)
      tt <= 2'h0;
      settle();
    end
    done("turbine");
    close_out();
  end
endmodule

// ---- pkg/rtil_defs.vh ----
/*
  Constants for the reactor trip interlock logic: register offsets, field
  positions of the train trouble vectors, reset values and bus timing.
  Assumes inclusion by a design file that owns the APB slave.
*/
`ifndef RTIL_DEFS_VH
`define RTIL_DEFS_VH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define RTIL_OFS_CTRL     8'h00
`define RTIL_OFS_STATUS   8'h04
`define RTIL_OFS_TROUBLE  8'h08

// ****************************************************************
// control register fields (write one to pulse)
// ****************************************************************
`define RTIL_CTRL_SR_BLK  0
`define RTIL_CTRL_SR_RST  1

// ****************************************************************
// train health vector, one bit per condition, 1 = normal
// ****************************************************************
`define RTIL_TRN_W        12
`define RTIL_TRN_48V0     0
`define RTIL_TRN_48V1     1
`define RTIL_TRN_15V0     2
`define RTIL_TRN_15V1     3
`define RTIL_TRN_CARD     4
`define RTIL_TRN_IEI      5
`define RTIL_TRN_SRT      6
`define RTIL_TRN_MUX      7
`define RTIL_TRN_BYP      8
`define RTIL_TRN_SRCAB    9
`define RTIL_TRN_PMTST    10
`define RTIL_TRN_LFTST    11

// ****************************************************************
// reset values and answers
// ****************************************************************
`define RTIL_SR_BLK_RST   1'b0
`define RTIL_BLK_RST      2'h0
`define RTIL_SW_HIST_RST  2'h3
`define RTIL_RDATA_RST    32'h00000000
`define RTIL_BUS_WAIT     1

`endif

// ---- src/rtil_top.v ----
/*
  Reactor trip interlock logic: general warning coincidence across the two
  logic trains, startup permissives and trip blocks, low power blocks and
  turbine trip sensing, with an APB slave for operator commands and status.
  Assumes all plant inputs are asynchronous bistable levels where voltage
  means normal, and a single 100 MHz clock with synchronous reset.
*/
// Chosen here: the APB register port and the register offsets.
// Functional notes
// R01: trip the reactor when both trains show any trouble at once.
// R02: annunciate trouble for each train on its own.
// R03: loss of any 48 V or 15 V supply of a train is trouble.
// R04: inhibit switch, relay tester in test or multiplex inhibit is trouble.
// R05: unseated card, closed bypass, cabinet power lost or test switch on.
// R06: intermediate permissive on one of two channels; gates source range block.
// R07: both intermediate channels below setpoint restore source range trip.
// R08: two manual resets restore source range trip between the permissives.
// R09: power range permissive forces source range block and high voltage off.
// R10: intermediate and low power range blocks need two of four channels.
// R11: four blocking switches, one per train per trip.
// R12: three of four power range channels below re-enable both trips.
// R13: low power interlock blocks multi-loop flow, pump and pressurizer trips.
// R14: low power is three of four flux below and both impulse below.
// R15: single-loop flow trip blocked when three of four flux below.
// R16: with that block active, flow trip needs two loops low.
// R17: turbine trip block active when three of four flux below.
// R18: turbine trip on all stop valves closed or two of three low pressure.
// R19: inputs are energised when normal; trip removes output voltage.
// R20: coincidences are level logic; only block commands are latched.
`timescale 1ns/1ps
`include "rtil_defs.vh"

module rtil_top #(
  parameter NUM_SV = 4
) (
  input  wire              MCLK,
  input  wire              SRST,
  input  wire              PSEL,
  input  wire              PENABLE,
  input  wire              PWRITE,
  input  wire [7:0]        PADDR,
  input  wire [31:0]       PWDATA,
  output reg  [31:0]       PRDATA,
  output reg               PREADY,
  output reg               PSLVERR,
  input  wire [11:0]       TRN_A_OK,
  input  wire [11:0]       TRN_B_OK,
  input  wire [1:0]        IR_BELOW,
  input  wire [3:0]        PR_BELOW,
  input  wire [1:0]        IMP_BELOW,
  input  wire [NUM_SV-1:0] SV_OPEN,
  input  wire [2:0]        TFP_OK,
  input  wire              SR_RESET_A,
  input  wire              SR_RESET_B,
  input  wire [1:0]        IR_BLK_SW,
  input  wire [1:0]        PRL_BLK_SW,
  input  wire [3:0]        LOOP_FLOW_OK,
  input  wire              RCP_UV_OK,
  input  wire              RCP_UF_OK,
  input  wire              PZR_LP_OK,
  input  wire              PZR_HL_OK,
  input  wire              SR_HI_OK,
  input  wire              IR_HI_OK,
  input  wire              PRL_HI_OK,
  output reg               TRIP_N,
  output reg               GW_TRIP_N,
  output reg               ALARM_A,
  output reg               ALARM_B,
  output reg               P6,
  output reg               P7,
  output reg               P8,
  output reg               P9,
  output reg               P10,
  output reg               SR_BLOCKED,
  output reg               HV_ON,
  output reg  [1:0]        IR_BLOCKED,
  output reg  [1:0]        PRL_BLOCKED,
  output reg               TURB_TRIP
);

  localparam IN_W = 2 * `RTIL_TRN_W + 2 + 4 + 2 + NUM_SV + 3 + 2 + 2 + 2 + 4 + 4 + 3;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // all plant levels are asynchronous; a single wide pair keeps them aligned
  wire [IN_W-1:0] raw_in;
  reg  [IN_W-1:0] meta_q;
  reg  [IN_W-1:0] sync_q;

  assign raw_in = {TRN_A_OK, TRN_B_OK, IR_BELOW, PR_BELOW, IMP_BELOW, SV_OPEN,
                   TFP_OK, SR_RESET_A, SR_RESET_B, IR_BLK_SW, PRL_BLK_SW,
                   LOOP_FLOW_OK, RCP_UV_OK, RCP_UF_OK, PZR_LP_OK, PZR_HL_OK,
                   SR_HI_OK, IR_HI_OK, PRL_HI_OK};

  always @(posedge MCLK)
  begin
    if (SRST)
    begin
      meta_q <= {IN_W{1'b1}};
      sync_q <= {IN_W{1'b1}};
    end
    else
    begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  wire [11:0]       trn_a;
  wire [11:0]       trn_b;
  wire [1:0]        ir_below;
  wire [3:0]        pr_below;
  wire [1:0]        imp_below;
  wire [NUM_SV-1:0] sv_open;
  wire [2:0]        tfp_ok;
  wire              sr_rst_a;
  wire              sr_rst_b;
  wire [1:0]        ir_sw;
  wire [1:0]        prl_sw;
  wire [3:0]        flow_ok;
  wire              uv_ok;
  wire              uf_ok;
  wire              lp_ok;
  wire              hl_ok;
  wire              sr_ok;
  wire              ir_ok;
  wire              prl_ok;

  assign {trn_a, trn_b, ir_below, pr_below, imp_below, sv_open, tfp_ok,
          sr_rst_a, sr_rst_b, ir_sw, prl_sw, flow_ok, uv_ok, uf_ok, lp_ok,
          hl_ok, sr_ok, ir_ok, prl_ok} = sync_q;

  // ****************************************************************
  // general warning
  // ****************************************************************
  // any cleared health bit is trouble; supplies, switches and cabinet alike
  wire trouble_a;
  wire trouble_b;

  assign trouble_a = ~&trn_a;  // see R03 see R04 see R05
  assign trouble_b = ~&trn_b;  // see R03 see R04 see R05

  // ****************************************************************
  // permissives
  // ****************************************************************
  wire [2:0] pr_below_cnt;
  wire       p6_d;
  wire       p10_d;
  wire       pr_3of4_below;
  wire       p7_d;
  wire       p8_d;
  wire       p9_d;

  assign pr_below_cnt  = {2'h0, pr_below[0]} + {2'h0, pr_below[1]}
                       + {2'h0, pr_below[2]} + {2'h0, pr_below[3]};
  assign p6_d          = ~&ir_below;                      // see R06
  assign pr_3of4_below = (pr_below_cnt >= 3'h3);
  // two of four above is exactly the complement of three of four below
  assign p10_d         = ~pr_3of4_below;                  // see R10
  assign p7_d          = ~(pr_3of4_below & (&imp_below)); // see R14
  // p8 and p9 share one flux vote; distinct setpoints would need their own pins
  assign p8_d          = ~pr_3of4_below;                  // see R15
  assign p9_d          = ~pr_3of4_below;                  // see R17

  // ****************************************************************
  // APB slave
  // ****************************************************************
  reg        sr_blk_req_q;
  reg        sr_rst_req_q;
  wire       acc;
  wire       hit_ctrl;
  wire       hit_stat;
  wire       hit_trb;
  reg [31:0] rdata_d;

  // one wait state always: the access edge registers the answer
  assign acc      = PSEL & PENABLE & ~PREADY;
  assign hit_ctrl = (PADDR == `RTIL_OFS_CTRL);
  assign hit_stat = (PADDR == `RTIL_OFS_STATUS);
  assign hit_trb  = (PADDR == `RTIL_OFS_TROUBLE);

  always @*
  begin
    rdata_d = `RTIL_RDATA_RST;
    if (hit_ctrl)
      rdata_d = `RTIL_RDATA_RST;
    else if (hit_stat)
      rdata_d = {16'h0000, TURB_TRIP, PRL_BLOCKED, IR_BLOCKED, HV_ON,
                 SR_BLOCKED, P10, P9, P8, P7, P6, ALARM_B, ALARM_A,
                 GW_TRIP_N, TRIP_N};
    else if (hit_trb)
      rdata_d = {4'h0, trn_b, 4'h0, trn_a};
  end

  always @(posedge MCLK)
  begin
    if (SRST)
    begin
      PREADY       <= 1'b0;
      PSLVERR      <= 1'b0;
      PRDATA       <= `RTIL_RDATA_RST;
      sr_blk_req_q <= 1'b0;
      sr_rst_req_q <= 1'b0;
    end
    else
    begin
      PREADY       <= acc;
      PSLVERR      <= acc & ~(hit_ctrl | hit_stat | hit_trb);
      PRDATA       <= (acc & ~PWRITE) ? rdata_d : `RTIL_RDATA_RST;
      // command bits are one-cycle pulses, never stored
      sr_blk_req_q <= acc & PWRITE & hit_ctrl & PWDATA[`RTIL_CTRL_SR_BLK];
      sr_rst_req_q <= acc & PWRITE & hit_ctrl & PWDATA[`RTIL_CTRL_SR_RST];
    end
  end

  // ****************************************************************
  // source range block
  // ****************************************************************
  // the block is the only stored state here; everything else follows levels
  reg  sr_blk_q;
  reg  sr_blk_d;
  wire man_reset;

  assign man_reset = sr_rst_a | sr_rst_b | sr_rst_req_q;  // see R08

  always @*
  begin
    sr_blk_d = sr_blk_q;
    if (!p10_d & man_reset)
      sr_blk_d = 1'b0;         // see R08
    else if (sr_blk_req_q & p6_d)
      sr_blk_d = 1'b1;         // see R06 see R20
    if (!p6_d)
      sr_blk_d = 1'b0;         // see R07
    if (p10_d)
      sr_blk_d = 1'b1;         // see R09
  end

  always @(posedge MCLK)
  begin
    if (SRST)
      sr_blk_q <= `RTIL_SR_BLK_RST;
    else
      sr_blk_q <= sr_blk_d;
  end

  // ****************************************************************
  // intermediate and low power range blocks, per train
  // ****************************************************************
  reg  [1:0] ir_sw_q;
  reg  [1:0] prl_sw_q;
  reg  [1:0] ir_blk_q;
  reg  [1:0] prl_blk_q;

  always @(posedge MCLK)
  begin
    if (SRST)
    begin
      // history matches the synchroniser reset level: no false edge on release
      ir_sw_q  <= `RTIL_SW_HIST_RST;
      prl_sw_q <= `RTIL_SW_HIST_RST;
    end
    else
    begin
      ir_sw_q  <= ir_sw;
      prl_sw_q <= prl_sw;
    end
  end

  genvar t;
  generate
    for (t = 0; t < 2; t = t + 1)
    begin : g_train
      // edge-armed so a switch left on cannot re-block after auto reset
      always @(posedge MCLK)
      begin
        if (SRST)
        begin
          ir_blk_q[t]  <= 1'b0;
          prl_blk_q[t] <= 1'b0;
        end
        else
        begin
          if (!p10_d)
            ir_blk_q[t] <= 1'b0;                          // see R12
          else if (ir_sw[t] & ~ir_sw_q[t])
            ir_blk_q[t] <= 1'b1;                          // see R10 see R11
          if (!p10_d)
            prl_blk_q[t] <= 1'b0;                         // see R12
          else if (prl_sw[t] & ~prl_sw_q[t])
            prl_blk_q[t] <= 1'b1;                         // see R10 see R11
        end
      end
    end
  endgenerate

  // ****************************************************************
  // trip demands
  // ****************************************************************
  wire [2:0] loops_low;
  wire [1:0] tfp_low_cnt;
  wire       turb_d;
  wire       flow_trip;
  wire       lp_trip;
  wire       turb_trip;
  wire       range_trip;
  wire       gw_d;
  wire       trip_d;

  assign loops_low   = {2'h0, ~flow_ok[0]} + {2'h0, ~flow_ok[1]}
                     + {2'h0, ~flow_ok[2]} + {2'h0, ~flow_ok[3]};
  assign tfp_low_cnt = {1'b0, ~tfp_ok[0]} + {1'b0, ~tfp_ok[1]}
                     + {1'b0, ~tfp_ok[2]};
  assign turb_d      = ~|sv_open | (tfp_low_cnt >= 2'h2);        // see R18
  // one loop trips only above the single-loop interlock
  assign flow_trip   = (p8_d & (loops_low >= 3'h1))              // see R15
                     | (p7_d & (loops_low >= 3'h2));             // see R16 see R13
  assign lp_trip     = p7_d & (~uv_ok | ~uf_ok | ~lp_ok | ~hl_ok); // see R13
  assign turb_trip   = p9_d & turb_d;                            // see R17
  // a range trip acts while either train leaves it unblocked
  assign range_trip  = (~sr_ok & ~sr_blk_q)
                     | (~ir_ok & ~&ir_blk_q)
                     | (~prl_ok & ~&prl_blk_q);
  assign gw_d        = trouble_a & trouble_b;                    // see R01
  assign trip_d      = gw_d
                     | flow_trip
                     | lp_trip
                     | turb_trip
                     | range_trip;

  // ****************************************************************
  // output registers
  // ****************************************************************
  // reset leaves outputs de-energised, the safe side
  always @(posedge MCLK)
  begin
    if (SRST)
    begin
      TRIP_N      <= 1'b0;
      GW_TRIP_N   <= 1'b0;
      ALARM_A     <= 1'b0;
      ALARM_B     <= 1'b0;
      P6          <= 1'b0;
      P7          <= 1'b0;
      P8          <= 1'b0;
      P9          <= 1'b0;
      P10         <= 1'b0;
      SR_BLOCKED  <= 1'b0;
      HV_ON       <= 1'b0;
      IR_BLOCKED  <= `RTIL_BLK_RST;
      PRL_BLOCKED <= `RTIL_BLK_RST;
      TURB_TRIP   <= 1'b0;
    end
    else
    begin
      TRIP_N      <= ~trip_d;      // see R19
      GW_TRIP_N   <= ~gw_d;        // see R01 see R19
      ALARM_A     <= trouble_a;    // see R02
      ALARM_B     <= trouble_b;    // see R02
      P6          <= p6_d;
      P7          <= p7_d;
      P8          <= p8_d;
      P9          <= p9_d;
      P10         <= p10_d;
      SR_BLOCKED  <= sr_blk_d;
      HV_ON       <= ~sr_blk_d;    // see R09
      IR_BLOCKED  <= ir_blk_q;
      PRL_BLOCKED <= prl_blk_q;
      TURB_TRIP   <= turb_d;
    end
  end

endmodule
